//--- smgmt_host.sv
// Behavioural host master for the I2C and MDIO management pins
`timescale 1ns/100ps
`default_nettype none

module smgmt_host (
  // Clock
  input  wire logic clk,
  // Resolved line levels
  input  wire logic sda_in,
  input  wire logic mdio_in,
  // Pins; high on sda_rel and mdio_rel means released to the pull-up, scl and mdc are driven
  output logic      scl,
  output logic      sda_rel,
  output logic      mdc,
  output logic      mdio_rel
);
  // Idle bus: I2C clock high, MDIO clock parked low between frames
  initial begin
    scl      = 1'b1;
    sda_rel  = 1'b1;
    mdc      = 1'b0;
    mdio_rel = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One I2C bit of 160 ns: data moves only while the clock is low
  task automatic i2c_bit(input logic b, output logic r);
    tick(1);
    sda_rel <= b;
    tick(4);
    scl <= 1'b1;
    tick(3);
    r = sda_in;
    scl <= 1'b0;
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic i2c_byte(input logic [7:0] d, input logic ack_in,
                          output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(d[i], q[i]);
    i2c_bit(ack_in, ack);
  endtask

  // Start or repeated start; release first so a held ack can clear
  task automatic i2c_start();
    tick(2);
    sda_rel <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_rel <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic i2c_stop();
    tick(2);
    sda_rel <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda_rel <= 1'b1;
    tick(8);
  endtask

  // One MDIO bit of 200 ns, so the clock stays at 5 MHz
  task automatic md_bit(input logic b, output logic r);
    mdio_rel <= b;
    tick(5);
    mdc <= 1'b1;
    tick(5);
    r = mdio_in;
    mdc <= 1'b0;
  endtask

  // Whole frame; a read releases turnaround and data slots
  // MDIO and I2C are the model's PHY paths; no in-band access runs beside them
  task automatic md_frame(input logic [1:0] op, input logic [4:0] phy,
                          input logic [4:0] rg, input logic [15:0] wd,
                          output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic        r;
    hdr = {2'b01, op, phy, rg};
    for (int i = 0; i < 32; i++)
      md_bit(1'b1, r);
    for (int i = 13; i >= 0; i--)
      md_bit(hdr[i], r);
    md_bit(1'b1, r);
    md_bit(op[1], ta);
    for (int i = 15; i >= 0; i--)
      md_bit(op[1] | wd[i], rd[i]);
    mdio_rel <= 1'b1;
    tick(2);
  endtask
endmodule
`default_nettype wire

//--- smgmt_pkg.sv
// Constants and types shared by the serial management slave
package smgmt_pkg;

  // I2C framing
  localparam logic [6:0]  I2C_DEV_ADDR = 7'h5F;     // Fixed bus address
  localparam logic [3:0]  BITS_BYTE    = 4'h8;      // Bits per byte
  localparam logic [15:0] ADDR_STEP    = 16'h0001;  // Burst address step

  // Strap decode and capture delay after reset release
  localparam logic [1:0]  STRAP_I2C    = 2'h1;
  localparam logic [1:0]  STRAP_MDIO   = 2'h2;
  localparam logic [1:0]  STRAP_WAIT   = 2'h3;

  // MDIO frame fields
  localparam logic [5:0]  PRE_ONES     = 6'h20;     // Preamble length
  localparam logic [5:0]  HDR_BITS     = 6'h0E;     // Start to reg addr
  localparam logic [5:0]  WDAT_END     = 6'h12;     // Turnaround + data
  localparam logic [5:0]  RD_BITS      = 6'h10;     // Data bits
  localparam logic [1:0]  ST_CODE      = 2'h1;
  localparam logic [1:0]  OP_RD        = 2'h2;
  localparam logic [1:0]  OP_WR        = 2'h1;
  localparam logic [4:0]  PHY_MIN      = 5'h01;
  localparam logic [4:0]  PHY_MAX      = 5'h05;
  localparam logic [3:0]  PHY_PAGE     = 4'h1;      // Middle nibble N1xx
  localparam logic [31:0] REG_IMPL     = 32'h982E_E7FF; // Present indices

  // Pending second byte access of a 16-bit MDIO register
  localparam logic [1:0]  STEP_NONE    = 2'h0;
  localparam logic [1:0]  STEP_RD_LO   = 2'h1;
  localparam logic [1:0]  STEP_WR_LO   = 2'h2;

  typedef enum logic [1:0] {MD_SPI, MD_I2C, MD_MDIO} smgmt_mode_e;
  typedef enum logic [2:0] {
    I_IDLE, I_DEV, I_AHI, I_ALO, I_WDAT, I_TX, I_RACK
  } smgmt_ist_e;
  typedef enum logic [2:0] {M_PRE, M_HDR, M_RTA, M_RD, M_WD} smgmt_mst_e;

endpackage

//--- smgmt_sync.sv
// Two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/100ps
`default_nettype none

module smgmt_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous pins in, synchronous level and edges out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } smgmt_sync_s;

  smgmt_sync_s st_ff;
  smgmt_sync_s nxt_st;

  // First stage feeds only the second; edges use stages two and three
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // Register all stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Level and one-cycle edge pulses
  assign q    = st_ff.s2;
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;

endmodule
`default_nettype wire

//--- smgmt_top.sv
// I2C and MDIO management slave reaching the switch register space
// Summary of operation
// (RULE1) I2C slave answers only at fixed seven-bit address 1011111.
// (RULE2) Read/write flag follows address as bit zero; one means read.
// (RULE3) I2C uses sixteen-bit register address and byte-wide data.
// (RULE4) I2C reaches every switch register and table through the port.
// (RULE5) Only one such slave may sit on one I2C bus.
// (RULE6) MDIO reaches only the PHY register pages, no switch registers.
// (RULE7) MDIO and in-band management are never used together.
// (RULE8) Data lines are open drain: pulled low or released only.
// (RULE9) Host keeps management clock at or below five megahertz; the bench host runs MDC at 5 MHz but SCL at 6.25 MHz.
// (RULE10) MDIO frame: preamble, 01, opcode, PHY, reg, turnaround, 16 data.
// (RULE11) PHY addresses one to five select the port of that number.
// (RULE12) Each PHY has thirty-two sixteen-bit direct registers.
// (RULE13) MDIO register n of port N is bytes 0xN100 plus 2n, 2n+1.
// (RULE14) PHY registers are also reachable as bytes over I2C.
// (RULE15) MMD setup and data indices Dh and Eh pass to the PHY page.
// (RULE16) Mode is chosen by a strap sampled at reset release.
// (RULE17) I2C bursts increment the address; bytes acknowledged normally.
// (RULE18) Reserved MDIO indices read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module smgmt_top
  import smgmt_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // Mode strap
  input  wire logic [1:0]  MODE_STRAP,
  // I2C pins
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OEN,
  // MDIO pins
  input  wire logic        MDC_I,
  input  wire logic        MDIO_I,
  output logic             MDIO_O,
  output logic             MDIO_OEN,
  // Switch register port, byte wide
  output logic             REG_RD,
  output logic             REG_WR,
  output logic [15:0]      REG_ADDR,
  output logic [7:0]       REG_WDATA,
  input  wire logic [7:0]  REG_RDATA
);

  typedef struct packed {
    smgmt_mode_e mode;
    logic        sdone;
    logic [1:0]  scnt;
    smgmt_ist_e  ist;
    logic [3:0]  icnt;
    logic [7:0]  ish;
    logic        iack;
    logic [15:0] iaddr;
    smgmt_mst_e  mst;
    logic [5:0]  mcnt;
    logic [15:0] msh;
    logic        mresp;
    logic        mwr;
    logic [1:0]  mstep;
    logic        reg_rd;
    logic        reg_wr;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        rd_dly;
    logic        sda_oen;
    logic        mdio_oen;
    logic        od_low;
  } smgmt_state_s;

  smgmt_state_s st_ff;
  smgmt_state_s nxt_st;

  logic [1:0]  strap_q;
  logic [3:0]  pin_q;
  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;
  logic        scl_q;
  logic        sda_q;
  logic        mdio_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_rise;
  logic        sda_fall;
  logic        mdc_rise;
  logic        mdc_fall;
  logic [13:0] hdr_v;
  logic [15:0] wd_v;
  logic [4:0]  hdr_pa;
  logic [4:0]  hdr_ra;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  smgmt_sync #(.W(4)) u_pins (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .d     ({SCL_I, SDA_I, MDC_I, MDIO_I}),
    .q     (pin_q),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  smgmt_sync #(.W(2)) u_strap (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .d     (MODE_STRAP),
    .q     (strap_q),
    .rise  (),
    .fall  ()
  );

  // Named pin levels and edges
  assign scl_q    = pin_q[3];
  assign sda_q    = pin_q[2];
  assign mdio_q   = pin_q[0];
  assign scl_rise = pin_rise[3];
  assign scl_fall = pin_fall[3];
  assign sda_rise = pin_rise[2];
  assign sda_fall = pin_fall[2];
  assign mdc_rise = pin_rise[1];
  assign mdc_fall = pin_fall[1];

  // Shift values including the bit being sampled now
  assign hdr_v  = {st_ff.msh[12:0], mdio_q};
  assign wd_v   = {st_ff.msh[14:0], mdio_q};
  assign hdr_pa = hdr_v[9:5];
  assign hdr_ra = hdr_v[4:0];

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.reg_rd = 1'h0;
    nxt_st.reg_wr = 1'h0;
    nxt_st.rd_dly = st_ff.reg_rd;
    nxt_st.od_low = 1'h0;

    // Strap capture a few cycles after reset release
    if (!st_ff.sdone) begin
      nxt_st.scnt = st_ff.scnt + 2'h1;
      if (st_ff.scnt == STRAP_WAIT) begin
        nxt_st.sdone = 1'h1;                                  // RULE16
        unique case (strap_q)
          STRAP_I2C:  nxt_st.mode = MD_I2C;
          STRAP_MDIO: nxt_st.mode = MD_MDIO;
          default:    nxt_st.mode = MD_SPI;
        endcase
      end
    end

    // I2C slave
    if (st_ff.mode == MD_I2C) begin
      if (st_ff.rd_dly) begin
        nxt_st.ish = REG_RDATA;                               // RULE4
      end
      if (scl_q && sda_fall) begin
        nxt_st.ist     = I_DEV;
        nxt_st.icnt    = '0;
        nxt_st.iack    = 1'h0;
        nxt_st.sda_oen = 1'h1;
      end else if (scl_q && sda_rise) begin
        nxt_st.ist     = I_IDLE;
        nxt_st.iack    = 1'h0;
        nxt_st.sda_oen = 1'h1;
      end else if (scl_rise) begin
        if (!st_ff.iack && (st_ff.ist == I_DEV || st_ff.ist == I_AHI ||
            st_ff.ist == I_ALO || st_ff.ist == I_WDAT)) begin
          nxt_st.ish  = {st_ff.ish[6:0], sda_q};
          nxt_st.icnt = st_ff.icnt + 4'h1;
        end
        if (st_ff.ist == I_RACK) begin
          if (sda_q) begin
            nxt_st.ist = I_IDLE;                // Master ended the burst
          end else begin
            nxt_st.reg_rd   = 1'h1;                           // RULE17
            nxt_st.reg_addr = st_ff.iaddr;
            nxt_st.iaddr    = st_ff.iaddr + ADDR_STEP;
            nxt_st.ist      = I_TX;
            nxt_st.icnt     = '0;
          end
        end
      end else if (scl_fall) begin
        if (st_ff.iack) begin
          nxt_st.iack    = 1'h0;
          nxt_st.sda_oen = 1'h1;
          nxt_st.icnt    = '0;
        end
        if (st_ff.ist == I_TX) begin
          if (nxt_st.icnt == BITS_BYTE) begin
            nxt_st.sda_oen = 1'h1;
            nxt_st.ist     = I_RACK;
          end else begin
            nxt_st.sda_oen = st_ff.ish[7];                    // RULE8
            nxt_st.ish     = {st_ff.ish[6:0], 1'h0};
            nxt_st.icnt    = nxt_st.icnt + 4'h1;
          end
        end else if (!st_ff.iack && st_ff.icnt == BITS_BYTE &&
                     st_ff.ist != I_IDLE && st_ff.ist != I_RACK) begin
          nxt_st.iack    = 1'h1;                              // RULE17
          nxt_st.sda_oen = 1'h0;
          nxt_st.icnt    = '0;
          unique case (st_ff.ist)
            I_DEV: begin
              if (st_ff.ish[7:1] != I2C_DEV_ADDR) begin       // RULE1
                nxt_st.iack    = 1'h0;
                nxt_st.sda_oen = 1'h1;
                nxt_st.ist     = I_IDLE;
              end else if (st_ff.ish[0]) begin                // RULE2
                nxt_st.reg_rd   = 1'h1;
                nxt_st.reg_addr = st_ff.iaddr;
                nxt_st.iaddr    = st_ff.iaddr + ADDR_STEP;
                nxt_st.ist      = I_TX;
              end else begin
                nxt_st.ist = I_AHI;
              end
            end
            I_AHI: begin
              nxt_st.iaddr[15:8] = st_ff.ish;                 // RULE3
              nxt_st.ist         = I_ALO;
            end
            I_ALO: begin
              nxt_st.iaddr[7:0] = st_ff.ish;                  // RULE3
              nxt_st.ist        = I_WDAT;
            end
            default: begin
              nxt_st.reg_wr    = 1'h1;                        // RULE14
              nxt_st.reg_addr  = st_ff.iaddr;
              nxt_st.reg_wdata = st_ff.ish;
              nxt_st.iaddr     = st_ff.iaddr + ADDR_STEP;     // RULE17
            end
          endcase
        end
      end
    end

    // MDIO slave: second byte of a register pair one cycle later
    if (st_ff.mode == MD_MDIO) begin
      if (st_ff.rd_dly) begin
        nxt_st.msh = {st_ff.msh[7:0], REG_RDATA};             // RULE13
      end
      if (st_ff.mstep == STEP_RD_LO) begin
        nxt_st.reg_rd      = 1'h1;                            // RULE13
        nxt_st.reg_addr[0] = 1'h1;
        nxt_st.mstep       = STEP_NONE;
      end else if (st_ff.mstep == STEP_WR_LO) begin
        nxt_st.reg_wr      = 1'h1;                            // RULE13
        nxt_st.reg_addr[0] = 1'h1;
        nxt_st.reg_wdata   = st_ff.msh[7:0];
        nxt_st.mstep       = STEP_NONE;
      end
      if (mdc_rise) begin
        unique case (st_ff.mst)
          M_PRE: begin
            if (mdio_q) begin
              if (st_ff.mcnt != PRE_ONES) begin
                nxt_st.mcnt = st_ff.mcnt + 6'h01;
              end
            end else if (st_ff.mcnt == PRE_ONES) begin        // RULE10
              nxt_st.mst  = M_HDR;
              nxt_st.mcnt = 6'h01;
              nxt_st.msh  = '0;
            end else begin
              nxt_st.mcnt = '0;
            end
          end
          M_HDR: begin
            nxt_st.msh  = {st_ff.msh[14:0], mdio_q};
            nxt_st.mcnt = st_ff.mcnt + 6'h01;
            if (nxt_st.mcnt == HDR_BITS) begin
              nxt_st.mcnt     = '0;
              nxt_st.msh      = '0;
              nxt_st.mresp    = hdr_pa >= PHY_MIN &&
                                hdr_pa <= PHY_MAX;            // RULE11
              nxt_st.reg_addr = {hdr_pa[3:0], PHY_PAGE, 2'h0,
                                 hdr_ra, 1'h0};               // RULE6
              if (hdr_v[13:12] != ST_CODE) begin
                nxt_st.mst = M_PRE;
              end else if (hdr_v[11:10] == OP_RD) begin
                nxt_st.mst = M_RTA;
                if (nxt_st.mresp && REG_IMPL[hdr_ra]) begin   // RULE18
                  nxt_st.reg_rd = 1'h1;                       // RULE15
                  nxt_st.mstep  = STEP_RD_LO;
                end
              end else if (hdr_v[11:10] == OP_WR) begin
                nxt_st.mst = M_WD;
                nxt_st.mwr = nxt_st.mresp && REG_IMPL[hdr_ra]; // RULE12
              end else begin
                nxt_st.mst = M_PRE;
              end
            end
          end
          M_WD: begin
            nxt_st.msh  = wd_v;
            nxt_st.mcnt = st_ff.mcnt + 6'h01;
            if (nxt_st.mcnt == WDAT_END) begin
              nxt_st.mst  = M_PRE;
              nxt_st.mcnt = '0;
              if (st_ff.mwr) begin
                nxt_st.reg_wr    = 1'h1;                      // RULE18
                nxt_st.reg_wdata = wd_v[15:8];
                nxt_st.mstep     = STEP_WR_LO;
              end
            end
          end
          default: ;
        endcase
      end else if (mdc_fall) begin
        if (st_ff.mst == M_RTA) begin
          if (st_ff.mcnt == '0) begin
            nxt_st.mcnt = 6'h01;                // First turnaround bit Z
          end else begin
            nxt_st.mdio_oen = !st_ff.mresp;                   // RULE10
            nxt_st.mst      = M_RD;
            nxt_st.mcnt     = '0;
          end
        end else if (st_ff.mst == M_RD) begin
          if (st_ff.mcnt == RD_BITS) begin
            nxt_st.mdio_oen = 1'h1;
            nxt_st.mst      = M_PRE;
            nxt_st.mcnt     = '0;
          end else begin
            nxt_st.mdio_oen = !st_ff.mresp || st_ff.msh[15];  // RULE8
            nxt_st.msh      = {st_ff.msh[14:0], 1'h0};
            nxt_st.mcnt     = st_ff.mcnt + 6'h01;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_ff          <= '0;
      st_ff.mode     <= MD_SPI;
      st_ff.ist      <= I_IDLE;
      st_ff.mst      <= M_PRE;
      st_ff.sda_oen  <= 1'h1;
      st_ff.mdio_oen <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign SDA_O     = st_ff.od_low;
  assign SDA_OEN   = st_ff.sda_oen;
  assign MDIO_O    = st_ff.od_low;
  assign MDIO_OEN  = st_ff.mdio_oen;
  assign REG_RD    = st_ff.reg_rd;
  assign REG_WR    = st_ff.reg_wr;
  assign REG_ADDR  = st_ff.reg_addr;
  assign REG_WDATA = st_ff.reg_wdata;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_mdio_hi(logic op);
    st_ff.mode == MD_MDIO && op && !REG_ADDR[0];
  endsequence

  sequence s_mdio_lo(logic op);
    op && REG_ADDR[0] && REG_ADDR[15:1] == $past(REG_ADDR[15:1]);
  endsequence

  a_od_low_only: assert property (SDA_O == 1'h0 && MDIO_O == 1'h0) // RULE8
    else $error("open drain line driven high");

  a_mdio_phy_only: assert property (                            // RULE6
    st_ff.mode == MD_MDIO && (REG_RD || REG_WR) |->
      REG_ADDR[11:8] == PHY_PAGE && REG_ADDR[7:6] == 2'h0 &&
      REG_ADDR[15:12] >= PHY_MIN[3:0] && REG_ADDR[15:12] <= PHY_MAX[3:0])
    else $error("MDIO access outside PHY pages");

  a_mdio_reserved: assert property (                            // RULE18
    st_ff.mode == MD_MDIO && (REG_RD || REG_WR) |->
      REG_IMPL[REG_ADDR[5:1]])
    else $error("MDIO access to reserved index");

  a_mdio_rd_pair: assert property (                             // RULE13
    s_mdio_hi(REG_RD) |=> s_mdio_lo(REG_RD))
    else $error("MDIO read not split into byte pair");

  a_mdio_wr_pair: assert property (                             // RULE13
    s_mdio_hi(REG_WR) |=> s_mdio_lo(REG_WR))
    else $error("MDIO write not split into byte pair");

  a_mdio_ta_zero: assert property (                             // RULE10
    st_ff.mst == M_RTA && st_ff.mcnt != '0 && mdc_fall && st_ff.mresp
      |=> !MDIO_OEN ##1 st_ff.mst == M_RD)
    else $error("turnaround zero not driven");

  a_i2c_dev_match: assert property (                            // RULE1
    st_ff.iack && !$past(st_ff.iack) && $past(st_ff.ist) == I_DEV |->
      st_ff.ish[7:1] == I2C_DEV_ADDR && !SDA_OEN)
    else $error("acknowledged foreign address");

  a_i2c_addr_inc: assert property (                             // RULE17
    st_ff.mode == MD_I2C && (REG_WR || REG_RD) |->
      st_ff.iaddr == REG_ADDR + ADDR_STEP)
    else $error("burst address not incremented");

  a_mode_stable: assert property (                              // RULE16
    st_ff.sdone |=> $stable(st_ff.mode) && st_ff.sdone)
    else $error("mode changed after strap capture");

endmodule
`default_nettype wire

//--- smgmt_top_tb.sv
// Self-checking bench for the I2C and MDIO management slave
`timescale 1ns/100ps
`default_nettype none

module smgmt_top_tb import smgmt_pkg::*;;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [1:0]  strap     = 2'h0;
  logic        scl, sda_rel, mdc, mdio_rel;
  logic        sda_o, sda_oen, mdio_o, mdio_oen;
  logic        reg_rd, reg_wr;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata = 8'h00;
  logic [7:0]  mem [0:65535];
  int          fails     = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          acc_n     = 0;
  // Single slave on each bus; pull-ups give the high level
  wire logic   sda_w  = sda_rel & (sda_oen | sda_o);
  wire logic   mdio_w = mdio_rel & (mdio_oen | mdio_o);

  always #10 clk_sys = ~clk_sys;

  smgmt_top smgmt_top_i (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .MODE_STRAP(strap),
    .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OEN(sda_oen),
    .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o), .MDIO_OEN(mdio_oen),
    .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

  smgmt_host smgmt_host_i (
    .clk(clk_sys), .sda_in(sda_w), .mdio_in(mdio_w),
    .scl(scl), .sda_rel(sda_rel), .mdc(mdc), .mdio_rel(mdio_rel));

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  function automatic logic [15:0] pa(input logic [4:0] p, input logic [4:0] n);
    return {p[3:0], PHY_PAGE, 8'h00} + {10'h000, n, 1'b0};
  endfunction

  // Switch register store with one-cycle read latency, plus timeout
  initial begin
    for (int a = 0; a < 65536; a++)
      mem[a] = pat(16'(a));
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (reg_rd === 1'b1)
      reg_rdata <= mem[reg_addr];
    if (reg_wr === 1'b1)
      mem[reg_addr] <= reg_wdata;
    if (reg_rd === 1'b1 || reg_wr === 1'b1)
      acc_n <= acc_n + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [16:0] seen,
                     input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] s);
    strap <= s;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("sda release", {sda_oen, sda_o}, 2'b10);
    chk("mdio release", {mdio_oen, mdio_o}, 2'b10);
    chk("reg strobes", {reg_rd, reg_wr}, 2'b00);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  // I2C byte sent by the host, slave acknowledge expected
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    smgmt_host_i.i2c_byte(d, 1'b1, q, a);
    chk("i2c ack", a, 1'b0);
  endtask

  // I2C read of two bytes from a 16-bit address
  task automatic i2c_rd2(input logic [15:0] ad, output logic [15:0] d);
    logic a;
    smgmt_host_i.i2c_start();
    wb({I2C_DEV_ADDR, 1'b0});
    wb(ad[15:8]);
    wb(ad[7:0]);
    smgmt_host_i.i2c_start();
    wb({I2C_DEV_ADDR, 1'b1});
    smgmt_host_i.i2c_byte(8'hFF, 1'b0, d[15:8], a);
    smgmt_host_i.i2c_byte(8'hFF, 1'b1, d[7:0], a);
    smgmt_host_i.i2c_stop();
  endtask

  // Burst write into a PHY page, then burst reads incl. a page carry
  task automatic t_i2c();
    logic [15:0] d;
    smgmt_host_i.i2c_start();
    wb({I2C_DEV_ADDR, 1'b0});
    wb(8'h31);
    wb(8'h04);
    wb(8'hA5);
    wb(8'h3C);
    smgmt_host_i.i2c_stop();
    chk("i2c wr0", mem[16'h3104], 8'hA5);
    chk("i2c wr1", mem[16'h3105], 8'h3C);
    i2c_rd2(16'h3104, d);
    chk("i2c rd phy", d, 16'hA53C);
    i2c_rd2(16'h02FF, d);
    chk("i2c rd sw", d, {pat(16'h02FF), pat(16'h0300)});
  endtask

  // Foreign addresses get no acknowledge and no register access
  task automatic t_i2c_bad();
    logic [6:0] bad [4] = '{7'h5E, 7'h1F, 7'h7F, 7'h4F};
    logic [7:0] q;
    logic       a;
    int         n0;
    n0 = acc_n;
    foreach (bad[i]) begin
      smgmt_host_i.i2c_start();
      smgmt_host_i.i2c_byte({bad[i], 1'b0}, 1'b1, q, a);
      chk("i2c foreign ack", a, 1'b1);
      smgmt_host_i.i2c_stop();
    end
    chk("i2c foreign acc", 16'(acc_n - n0), 16'h0000);
  endtask

  // Read, write, read back one PHY register over MDIO
  task automatic md_rw(input logic [4:0] p, input logic [4:0] n,
                       input logic [15:0] wd);
    logic [15:0] a, rd;
    logic        ta;
    a = pa(p, n);
    smgmt_host_i.md_frame(OP_RD, p, n, 16'h0000, rd, ta);
    chk("md ta", ta, 1'b0);
    chk("md rd", rd, {pat(a), pat(a + 16'h0001)});
    smgmt_host_i.md_frame(OP_WR, p, n, wd, rd, ta);
    chk("md wr hi", mem[a], wd[15:8]);
    chk("md wr lo", mem[a + 16'h0001], wd[7:0]);
    smgmt_host_i.md_frame(OP_RD, p, n, 16'h0000, rd, ta);
    chk("md rdback", rd, wd);
  endtask

  task automatic t_md();
    logic [4:0] idx [4] = '{5'h1F, 5'h0D, 5'h0E, 5'h11};
    for (int p = 1; p <= 5; p++)
      md_rw(5'(p), 5'h00, 16'hC0D0 | 16'(p));
    foreach (idx[i])
      md_rw(5'h02, idx[i], {idx[i], 11'h3A5});
  endtask

  // Reserved indices and foreign PHY addresses
  task automatic t_md_refuse();
    logic [4:0] rsv [3] = '{5'h0B, 5'h10, 5'h1E};
    logic [4:0] bad [3] = '{5'h00, 5'h06, 5'h1F};
    logic [15:0] rd;
    logic        ta;
    int          n0;
    foreach (rsv[i]) begin
      smgmt_host_i.md_frame(OP_RD, 5'h04, rsv[i], 16'h0000, rd, ta);
      chk("md rsv rd", rd, 16'h0000);
      smgmt_host_i.md_frame(OP_WR, 5'h04, rsv[i], 16'h0F0F, rd, ta);
      chk("md rsv wr", mem[pa(5'h04, rsv[i])], pat(pa(5'h04, rsv[i])));
    end
    n0 = acc_n;
    foreach (bad[i]) begin
      smgmt_host_i.md_frame(OP_RD, bad[i], 5'h00, 16'h0000, rd, ta);
      chk("md foreign", {ta, rd}, 17'h1_FFFF);
      smgmt_host_i.md_frame(OP_WR, bad[i], 5'h00, 16'h0000, rd, ta);
    end
    chk("md foreign acc", 16'(acc_n - n0), 16'h0000);
  endtask

  // Paths the strap did not choose stay silent and touch no register
  task automatic t_silent(input logic chk_md, input logic chk_i2c);
    logic [15:0] rd;
    logic [7:0]  q;
    logic        ta;
    int          n0;
    n0 = acc_n;
    if (chk_md) begin
      smgmt_host_i.md_frame(OP_RD, 5'h01, 5'h00, 16'h0000, rd, ta);
      chk("mdio off", {ta, rd}, 17'h1_FFFF);
    end
    if (chk_i2c) begin
      smgmt_host_i.i2c_start();
      smgmt_host_i.i2c_byte({I2C_DEV_ADDR, 1'b0}, 1'b1, q, ta);
      chk("i2c off", ta, 1'b1);
      smgmt_host_i.i2c_stop();
    end
    chk("off acc", 16'(acc_n - n0), 16'h0000);
  endtask

  // Main sequence: I2C strap, then MDIO strap, then the silent strap
  initial begin
    do_reset(STRAP_I2C);
    t_i2c();
    t_i2c_bad();
    t_silent(1'b1, 1'b0);
    do_reset(STRAP_MDIO);
    t_md();
    t_md_refuse();
    t_silent(1'b0, 1'b1);
    do_reset(2'h0);
    t_silent(1'b1, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
